/* File: include/freq_rate_pkg.sv */
package freq_rate_pkg;

    localparam int RATE_W = 16;
    localparam int FREQ_W = 16;
    localparam int TIME_W = 32;
    localparam int DLY_W = 19;
    localparam int CNT_W = 16;
    localparam int GRP_W = 3;
    localparam int EVT_W = 3;
    localparam int NUM_EV = 6;

    // One processing cycle is one tick; measurements arrive on this time base
    localparam int TICK_MS = 5;
    localparam int PRE_TRIG_MS = 20;
    localparam int PRE_DEPTH = PRE_TRIG_MS / TICK_MS;
    localparam int REC_DEPTH = 12;
    localparam int REC_IDX_W = 4;

    // Rates in mHz/s, so hysteresis 100 mHz/s and ratio steps of 0.005 p.u.
    localparam logic signed [17:0] HYST_MHZ = 18'sh00064;
    localparam logic [15:0] MAX_RATE_DEF = 16'h4e20;
    localparam logic [7:0] RATIO_SCALE = 8'hc8;
    localparam logic [15:0] RATIO_MAX = 16'hffff;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_START = 2'b01,
        ST_TRIP = 2'b10,
        ST_BLOCKED = 2'b11
    } stage_state_t;

    typedef enum logic [1:0] {
        DIR_RISING = 2'b00,
        DIR_FALLING = 2'b01,
        DIR_BOTH = 2'b10
    } dir_mode_t;

    // Event bit positions, also used as event codes in records
    localparam logic [EVT_W-1:0] EV_START_ON = 3'h0;
    localparam logic [EVT_W-1:0] EV_START_OFF = 3'h1;
    localparam logic [EVT_W-1:0] EV_TRIP_ON = 3'h2;
    localparam logic [EVT_W-1:0] EV_TRIP_OFF = 3'h3;
    localparam logic [EVT_W-1:0] EV_BLK_ON = 3'h4;
    localparam logic [EVT_W-1:0] EV_BLK_OFF = 3'h5;

    typedef struct packed {
        logic signed [RATE_W-1:0] rate;
        logic [FREQ_W-1:0] freq;
    } meas_t;

    typedef struct packed {
        logic [15:0] pickup;
        logic [15:0] max_rate;
        logic [DLY_W-1:0] delay;
        dir_mode_t mode;
        logic [GRP_W-1:0] group;
    } settings_t;

    typedef struct packed {
        logic [TIME_W-1:0] stamp;
        logic [EVT_W-1:0] evt;
        meas_t pre;
        meas_t fault;
        logic [GRP_W-1:0] group;
    } record_t;

    typedef struct packed {
        stage_state_t status;
        logic [15:0] rate_abs;
        logic [15:0] ratio;
        logic [DLY_W-1:0] expected;
        logic signed [DLY_W:0] remaining;
    } live_t;

endpackage

/* File: core/freq_rate_stage.sv */
`timescale 1ns/10ps
module freq_rate_stage
    import freq_rate_pkg::*;
(
    input wire logic clock,                         // 250 MHz clock
    input wire logic sys_rst,                       // Synchronous reset
    input wire logic tick,                          // Processing cycle strobe
    input wire logic block_in,                      // Blocking matrix input
    input wire freq_rate_pkg::meas_t meas,          // Rate and frequency
    input wire logic [freq_rate_pkg::TIME_W-1:0] time_now,  // Time stamp
    input wire freq_rate_pkg::settings_t settings,  // Active settings
    input wire logic [2:0] ev_sel_on,               // Store ON edges
    input wire logic [2:0] ev_sel_off,              // Store OFF edges
    input wire logic [2:0] cnt_clr,                 // Counter clear pulses
    input wire logic [freq_rate_pkg::REC_IDX_W-1:0] rec_idx, // 0 = newest
    output logic start_out,                         // Start output
    output logic trip_out,                          // Trip output
    output logic blocked_out,                       // Blocked output
    output freq_rate_pkg::live_t live,              // Live values
    output logic [freq_rate_pkg::NUM_EV-1:0] ev_pulse,  // Event pulses
    output logic [freq_rate_pkg::NUM_EV-1:0] ev_store,  // Buffer-selected
    output logic [freq_rate_pkg::TIME_W-1:0] ev_time,   // Event stamp
    output logic [freq_rate_pkg::CNT_W-1:0] cnt_start,  // Start count
    output logic [freq_rate_pkg::CNT_W-1:0] cnt_trip,   // Trip count
    output logic [freq_rate_pkg::CNT_W-1:0] cnt_block,  // Blocked count
    output freq_rate_pkg::record_t rec_out,         // Selected record
    output logic [freq_rate_pkg::REC_IDX_W-1:0] rec_count // Valid records
);
    import freq_rate_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Measurement conditioning and pick-up

    logic signed [17:0] rate_s;
    logic [16:0] rate_abs;
    logic signed [17:0] rate_dir;
    logic signed [17:0] pick_lvl;
    logic over_max;
    logic blk_now;
    logic pick_now;
    logic [24:0] ratio_full;
    logic [15:0] ratio_val;

    stage_state_t state_reg, state_next;
    logic pick_reg, pick_next;
    logic [DLY_W-1:0] elapsed_reg, elapsed_next;

    always_comb
    begin
        rate_s = 18'(meas.rate);
        rate_abs = rate_s[17] ? 17'(-rate_s) : 17'(rate_s);
        unique case (settings.mode)
            DIR_RISING: rate_dir = rate_s;
            DIR_FALLING: rate_dir = -rate_s;
            DIR_BOTH: rate_dir = 18'(rate_abs);
            default: rate_dir = 18'(rate_abs);
        endcase
        pick_lvl = 18'({2'b00, settings.pickup});
        over_max = rate_abs > 17'(settings.max_rate);
        // Hold until well below pick-up so a noisy rate cannot chatter
        if (pick_reg)
            pick_now = rate_dir > (pick_lvl - HYST_MHZ);
        else
            pick_now = rate_dir >= pick_lvl;
        blk_now = block_in | over_max;
        ratio_full = 25'(rate_abs) * 25'(RATIO_SCALE);
        if (settings.pickup == 16'h0000)
            ratio_val = RATIO_MAX;
        else if ((ratio_full / 25'(settings.pickup)) > 25'(RATIO_MAX))
            ratio_val = RATIO_MAX;
        else
            ratio_val = 16'(ratio_full / 25'(settings.pickup));
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage state machine, evaluated once per tick

    always_comb
    begin
        state_next = state_reg;
        pick_next = pick_reg;
        elapsed_next = elapsed_reg;
        if (tick)
        begin
            pick_next = pick_now;
            if (!pick_now)
            begin
                state_next = ST_NORMAL;
                elapsed_next = '0;
            end
            else
            begin
                unique case (state_reg)
                    ST_NORMAL:
                    begin
                        elapsed_next = '0;
                        if (blk_now)
                            state_next = ST_BLOCKED;
                        else
                            state_next = ST_START;
                    end
                    ST_START:
                    begin
                        if (blk_now)
                        begin
                            state_next = ST_BLOCKED;
                            elapsed_next = '0;
                        end
                        else if (elapsed_reg + 1'b1 >= settings.delay)
                        begin
                            state_next = ST_TRIP;
                            elapsed_next = settings.delay;
                        end
                        else
                            elapsed_next = elapsed_reg + 1'b1;
                    end
                    // Trip latches until pick-up releases; a late block cannot undo it
                    ST_TRIP: state_next = ST_TRIP;
                    // Held off until the pick-up condition itself goes away
                    ST_BLOCKED: state_next = ST_BLOCKED;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_NORMAL;
            pick_reg <= 1'b0;
            elapsed_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            pick_reg <= pick_next;
            elapsed_reg <= elapsed_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, events, counters and live values

    logic [NUM_EV-1:0] ev_next;
    logic [NUM_EV-1:0] store_next;
    logic st_on, tr_on, bl_on;
    logic [CNT_W-1:0] cnt_start_next, cnt_trip_next, cnt_block_next;
    live_t live_next;

    function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] cur,
                                                    input logic inc, input logic clr);
        // An occurrence in the clearing cycle is kept
        if (clr)
            count_step = inc ? CNT_W'(1) : '0;
        else
            count_step = cur + CNT_W'(inc);
    endfunction

    always_comb
    begin
        st_on = state_next == ST_START;
        tr_on = state_next == ST_TRIP;
        bl_on = state_next == ST_BLOCKED;
        ev_next = '0;
        ev_next[EV_START_ON] = st_on & !start_out;
        ev_next[EV_START_OFF] = !st_on & start_out;
        ev_next[EV_TRIP_ON] = tr_on & !trip_out;
        ev_next[EV_TRIP_OFF] = !tr_on & trip_out;
        ev_next[EV_BLK_ON] = bl_on & !blocked_out;
        ev_next[EV_BLK_OFF] = !bl_on & blocked_out;
        store_next = ev_next & {ev_sel_off[2], ev_sel_on[2], ev_sel_off[1],
                                ev_sel_on[1], ev_sel_off[0], ev_sel_on[0]};
        cnt_start_next = count_step(cnt_start, ev_next[EV_START_ON], cnt_clr[0]);
        cnt_trip_next = count_step(cnt_trip, ev_next[EV_TRIP_ON], cnt_clr[1]);
        cnt_block_next = count_step(cnt_block, ev_next[EV_BLK_ON], cnt_clr[2]);
        live_next.status = state_next;
        live_next.rate_abs = rate_abs[15:0];
        live_next.ratio = ratio_val;
        live_next.expected = settings.delay;
        if (state_next == ST_START)
            live_next.remaining = (DLY_W+1)'(settings.delay) - (DLY_W+1)'(elapsed_next);
        else
            live_next.remaining = '0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            start_out <= 1'b0;
            trip_out <= 1'b0;
            blocked_out <= 1'b0;
            ev_pulse <= '0;
            ev_store <= '0;
            ev_time <= '0;
            cnt_start <= '0;
            cnt_trip <= '0;
            cnt_block <= '0;
            live <= '0;
        end
        else
        begin
            start_out <= st_on;
            trip_out <= tr_on;
            blocked_out <= bl_on;
            ev_pulse <= ev_next;
            ev_store <= store_next;
            ev_time <= time_now;
            cnt_start <= cnt_start_next;
            cnt_trip <= cnt_trip_next;
            cnt_block <= cnt_block_next;
            live <= live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pre-trigger history and fault records

    meas_t hist_reg [PRE_DEPTH];
    meas_t hist_next [PRE_DEPTH];
    record_t rec_mem [REC_DEPTH];
    logic [REC_IDX_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [REC_IDX_W-1:0] count_next;
    logic rec_we;
    record_t rec_new;
    record_t rec_out_next;
    logic [REC_IDX_W:0] rd_addr;

    always_comb
    begin
        for (int i = 0; i < PRE_DEPTH; i++)
            hist_next[i] = hist_reg[i];
        if (tick)
        begin
            hist_next[0] = meas;
            for (int i = 1; i < PRE_DEPTH; i++)
                hist_next[i] = hist_reg[i-1];
        end
        rec_we = ev_next[EV_START_ON] | ev_next[EV_TRIP_ON] | ev_next[EV_BLK_ON];
        rec_new.stamp = time_now;
        rec_new.evt = ev_next[EV_TRIP_ON] ? EV_TRIP_ON :
                      (ev_next[EV_BLK_ON] ? EV_BLK_ON : EV_START_ON);
        rec_new.pre = hist_reg[PRE_DEPTH-1];
        rec_new.fault = meas;
        rec_new.group = settings.group;
        wr_ptr_next = wr_ptr_reg;
        count_next = rec_count;
        if (rec_we)
        begin
            // Ring overwrites the oldest entry once full
            wr_ptr_next = (wr_ptr_reg == REC_IDX_W'(REC_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (rec_count != REC_IDX_W'(REC_DEPTH))
                count_next = rec_count + 1'b1;
        end
        rd_addr = (REC_IDX_W+1)'(REC_DEPTH) + (REC_IDX_W+1)'(wr_ptr_reg)
                  - (REC_IDX_W+1)'(1) - (REC_IDX_W+1)'(rec_idx);
        if (rd_addr >= (REC_IDX_W+1)'(REC_DEPTH))
            rd_addr = rd_addr - (REC_IDX_W+1)'(REC_DEPTH);
        if (rec_idx < rec_count && rd_addr < (REC_IDX_W+1)'(REC_DEPTH))
            rec_out_next = rec_mem[rd_addr[REC_IDX_W-1:0]];
        else
            rec_out_next = '0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < PRE_DEPTH; i++)
                hist_reg[i] <= '0;
            wr_ptr_reg <= '0;
            rec_count <= '0;
            rec_out <= '0;
        end
        else
        begin
            for (int i = 0; i < PRE_DEPTH; i++)
                hist_reg[i] <= hist_next[i];
            wr_ptr_reg <= wr_ptr_next;
            rec_count <= count_next;
            rec_out <= rec_out_next;
        end
    end

    // Record storage is not reset; rec_count marks which entries are valid
    always_ff @(posedge clock)
    begin
        if (rec_we)
            rec_mem[wr_ptr_reg] <= rec_new;
    end

endmodule

/* File: dv/freq_rate_checker.sv */
`timescale 1ns/10ps
module freq_rate_checker
    import freq_rate_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic tick, // Strobe
    input wire freq_rate_pkg::settings_t settings, // Settings
    input wire logic [2:0] ev_sel_on, // ON select
    input wire logic [2:0] ev_sel_off, // OFF select
    input wire logic [2:0] cnt_clr, // Clears
    input wire logic start_out, // Start
    input wire logic trip_out, // Trip
    input wire logic blocked_out, // Blocked
    input wire freq_rate_pkg::live_t live, // Live values
    input wire logic [5:0] ev_pulse, // Events
    input wire logic [5:0] ev_store, // Stored events
    input wire logic [15:0] cnt_start, // Start count
    input wire logic [3:0] rec_count // Records
);
    import freq_rate_pkg::*;
    logic [5:0] sel_mask;
    assign sel_mask = {ev_sel_off[2], ev_sel_on[2], ev_sel_off[1], ev_sel_on[1],
        ev_sel_off[0], ev_sel_on[0]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_one_state;
        $onehot0({start_out, trip_out, blocked_out}) && (start_out == (live.status == ST_START));
    endproperty
    a_one_state: assert property (p_one_state)
        else $error("stage outputs disagree with status");
    property p_tick_only;
        !$past(tick) && !$past(sys_rst) |-> $stable(live.status) && ev_pulse == 6'h00;
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("state moved without a tick");
    property p_start_on;
        $rose(start_out) |-> ev_pulse[0] && live.remaining == {1'b0, $past(settings.delay)};
    endproperty
    a_start_on: assert property (p_start_on)
        else $error("start without event or full remaining time");
    property p_start_off;
        !$past(sys_rst) && $fell(start_out) |-> ev_pulse[1];
    endproperty
    a_start_off: assert property (p_start_off)
        else $error("start dropped without event");
    property p_trip_on;
        $rose(trip_out) |-> $past(start_out) && ev_pulse[2] && ev_pulse[1];
    endproperty
    a_trip_on: assert property (p_trip_on)
        else $error("trip not reached from start");
    property p_block_on;
        $rose(blocked_out) |-> ev_pulse[4] ##1 !trip_out;
    endproperty
    a_block_on: assert property (p_block_on)
        else $error("blocked without event or tripped");
    property p_store;
        ev_store == (ev_pulse & $past(sel_mask));
    endproperty
    a_store: assert property (p_store)
        else $error("stored events differ from selection");
    property p_cnt_start;
        ev_pulse[0] && !$past(cnt_clr[0]) && !$past(sys_rst) |-> cnt_start == $past(cnt_start) + 16'h1;
    endproperty
    a_cnt_start: assert property (p_cnt_start)
        else $error("start count did not step");
    property p_rec_count;
        rec_count <= 4'hc;
    endproperty
    a_rec_count: assert property (p_rec_count)
        else $error("record count above twelve");
endmodule

/* File: dv/freq_rate_partner.sv */
`timescale 1ns/10ps
module freq_rate_partner
(
    input wire logic clock, // Clock
    input wire logic run, // Tick enable
    input wire logic blk_req, // Requested block level
    output logic tick, // Processing strobe
    output logic block_in // Block to stage
);
    logic [1:0] div_reg = 2'h0;
    logic req_reg = 1'b0;
    initial tick = 1'b0;
    initial block_in = 1'b0;
    // Request is latched first so the bench never races the drive edge
    always @(posedge clock) req_reg <= blk_req;
    always @(negedge clock)
    begin
        div_reg <= run ? div_reg + 2'h1 : 2'h0;
        tick <= run && (div_reg == 2'h3);
        block_in <= req_reg;
    end
endmodule

/* File: dv/freq_rate_stage_tb.sv */
`timescale 1ns/10ps
module freq_rate_stage_tb;
    import freq_rate_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic blk_req = 1'b0;
    logic tick;
    logic block_in;
    meas_t meas = '0;
    logic [TIME_W-1:0] time_now = '0;
    settings_t settings;
    logic [2:0] ev_sel_on = 3'h7;
    logic [2:0] ev_sel_off = 3'h0;
    logic [2:0] cnt_clr = 3'h0;
    logic [REC_IDX_W-1:0] rec_idx = '0;
    logic start_out, trip_out, blocked_out;
    live_t live;
    logic [NUM_EV-1:0] ev_pulse, ev_store;
    logic [TIME_W-1:0] ev_time;
    logic [CNT_W-1:0] cnt_start, cnt_trip, cnt_block;
    record_t rec_out;
    logic [REC_IDX_W-1:0] rec_count;
    int n_mismatch = 0;
    int check_count = 0;

    always #2 clock = ~clock;
    freq_rate_partner part_u (.clock, .run(!sys_rst), .blk_req, .tick, .block_in);
    freq_rate_stage dut_u (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n)
        begin
            do @(posedge clock); while (tick !== 1'b1);
            @(negedge clock);
        end
    endtask
    task automatic outs(input logic [2:0] sta, input logic [5:0] ev);
        chk({start_out, trip_out, blocked_out}, sta);
        chk(ev_pulse, ev);
    endtask
    task automatic rd(input logic [3:0] idx);
        rec_idx = idx;
        repeat (2) @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_trip;
        time_now = 32'h1234_0001;
        meas = '{rate: 16'sh07d0, freq: 16'h1388};
        tk(1);
        outs(3'h4, 6'h01);
        chk({ev_store, ev_time[15:0]}, {6'h01, 16'h0001});
        chk({live.rate_abs, live.ratio}, 32'h07d0_0190);
        chk(live.expected, 19'h5);
        tk(4);
        chk(live.remaining, 20'h1);
        tk(1);
        outs(3'h2, 6'h06);
        chk({ev_store, cnt_trip}, {6'h04, 16'h1});
        meas.rate = '0;
        tk(1);
        outs(3'h0, 6'h08);
        chk(rec_count, 4'h2);
        chk({rec_out.evt, rec_out.group, rec_out.pre.rate}, {3'h2, 3'h5, 16'h07d0});
        rd(1);
        chk({rec_out.evt, rec_out.fault.rate}, {3'h0, 16'h07d0});
        $display("test trip done");
    endtask
    task automatic t_blk;
        blk_req = 1'b1;
        meas.rate = 16'sh07d0;
        tk(1);
        outs(3'h1, 6'h10);
        blk_req = 1'b0;
        tk(7);
        outs(3'h1, 6'h00);
        meas.rate = '0;
        tk(1);
        outs(3'h0, 6'h20);
        $display("test blocked done");
    endtask
    task automatic t_late;
        meas.rate = 16'sh07d0;
        tk(1);
        blk_req = 1'b1;
        @(negedge clock);
        blk_req = 1'b0;
        tk(1);
        outs(3'h4, 6'h00);
        blk_req = 1'b1;
        tk(1);
        outs(3'h1, 6'h12);
        chk(live.remaining, 20'h0);
        blk_req = 1'b0;
        meas.rate = '0;
        tk(1);
        $display("test late block done");
    endtask
    task automatic t_dir;
        dir_mode_t m[3] = '{DIR_RISING, DIR_FALLING, DIR_BOTH};
        logic [2:0] e[3] = '{3'h0, 3'h4, 3'h4};
        for (int i = 0; i < 3; i++)
        begin
            settings.mode = m[i];
            meas.rate = -16'sh07d0;
            tk(1);
            chk({start_out, trip_out, blocked_out}, e[i]);
            meas.rate = '0;
            tk(1);
        end
        settings.mode = DIR_RISING;
        $display("test direction done");
    endtask
    task automatic t_max;
        meas.rate = 16'sh4e20;
        tk(1);
        outs(3'h4, 6'h01);
        meas.rate = 16'sh61a8;
        tk(1);
        outs(3'h1, 6'h12);
        meas.rate = '0;
        tk(1);
        $display("test max rate done");
    endtask
    task automatic t_hyst;
        meas.rate = 16'sh03e8;
        tk(1);
        meas.rate = 16'sh0385;
        tk(1);
        chk(start_out, 1'b1);
        meas.rate = 16'sh0384;
        tk(1);
        outs(3'h0, 6'h02);
        $display("test hysteresis done");
    endtask
    task automatic t_count;
        chk({cnt_start, cnt_block}, {16'h6, 16'h3});
        cnt_clr = 3'h7;
        @(negedge clock);
        cnt_clr = 3'h0;
        chk(cnt_start | cnt_trip | cnt_block, 16'h0);
        for (int i = 1; i <= 13; i++)
        begin
            meas = '{rate: 16'sh07d0, freq: 16'(i)};
            tk(1);
            meas.rate = '0;
            tk(1);
        end
        chk({cnt_start, 12'h0, rec_count}, {16'hd, 16'hc});
        rd(0);
        chk(rec_out.fault.freq, 16'hd);
        rd(11);
        chk(rec_out.fault.freq, 16'h2);
        rd(12);
        chk(|rec_out, 1'b0);
        $display("test counters and records done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        settings = '{pickup: 16'h03e8, max_rate: MAX_RATE_DEF, delay: 19'h5,
            mode: DIR_RISING, group: 3'h5};
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        t_trip();
        t_blk();
        t_late();
        t_dir();
        t_max();
        t_hyst();
        t_count();
        finish_test();
    end
    // Whole run needs about 60 ticks of 16 ns
    initial
    begin
        #40000;
        n_mismatch++;
        finish_test();
    end
endmodule
bind freq_rate_stage freq_rate_checker chk_u (.*);
